// >>> rtl/iov_pkg.sv
// Notes on behaviour
// - a 16-bit trip threshold register at command code 0x55 sets the level for a fault.
// - a separate 16-bit alert threshold register at 0x57 sets the level for a warning.
// - reaction code 00 keeps the output running whatever the fault does.
// - reaction code 01 rides through the programmed delay, then uses the retry field if still faulted.
// - reaction code 10 disables the output at once and then follows the retry field in bits 5:3.
// - reaction code 11 holds the output off while the fault lasts and re-enables it once it is gone.
// - retry value 000 makes no restart attempt and keeps the output off until the fault is cleared.
// - retry values 001 to 110 give that many attempts, counted since the last off command, shutdown or clear, after which the output stays off until cleared.
// - the spacing between starts of restart attempts is the delay multiplier times the time unit.
// - retry value 111 retries without limit until an off command or another fault stops it.
// - the delay field selects a multiplier of two to the power of the field, 1 to 128 units.
// - the length of one delay time unit comes from a separate configuration value, not this register.
package iov_pkg;
    // command codes of the registers
    localparam logic [7:0] CMD_TRIP_THRESHOLD  = 8'h55;
    localparam logic [7:0] CMD_REACTION_CONFIG = 8'h56;
    localparam logic [7:0] CMD_ALERT_THRESHOLD = 8'h57;

    // reaction config field positions
    localparam int REACT_HI = 7;
    localparam int REACT_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;

    // reset values, chosen so that an unconfigured part never trips
    localparam logic [15:0] TRIP_RESET     = 16'hFFFF;
    localparam logic [15:0] ALERT_RESET    = 16'hFFFF;
    localparam logic [7:0]  REACTION_RESET = 8'h80;

    // retry field codes
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // reaction codes
    typedef enum logic [1:0] {
        IOV_IGNORE    = 2'h0,
        IOV_RIDE      = 2'h1,
        IOV_SHUT      = 2'h2,
        IOV_RESUME_OK = 2'h3
    } iov_react_t;
endpackage : iov_pkg

// >>> rtl/iov_cfg_if.sv
`timescale 1ns/1ps
// configuration fields passed from the register file and the unit_cycles input to the fault engine
interface iov_cfg_if;
    logic [1:0]  react;
    logic [2:0]  retries;
    logic [2:0]  delay_exp;
    logic [15:0] unit_cycles;
    modport src (output react, output retries, output delay_exp, output unit_cycles);
    modport dst (input react, input retries, input delay_exp, input unit_cycles);
endinterface : iov_cfg_if

// >>> rtl/iov_fault_engine.sv
`timescale 1ns/1ps
// fault reaction state machine with delay timer and retry counter
module iov_fault_engine (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // configuration
    iov_cfg_if.dst    cfg,
    // condition inputs
    input  wire logic fault,
    input  wire logic fault_clear,
    input  wire logic on_cmd,
    input  wire logic other_shutdown,
    // results
    output logic      out_enable,
    output logic      latched_off,
    output logic      in_delay
);
    typedef enum logic [2:0] {
        IOV_S_OFF, IOV_S_RUN, IOV_S_RIDE, IOV_S_WAIT, IOV_S_HOLD, IOV_S_LATCH
    } iov_state_t;

    iov_state_t  state_reg;
    logic [15:0] unit_cnt_reg;
    logic [7:0]  units_left_reg;
    logic [2:0]  attempts_reg;
    logic        timer_load;
    logic        tick;
    logic        timer_done;

    // one time unit per tick; unit length comes from outside the register
    assign tick       = (unit_cnt_reg == 16'h0000);
    assign timer_done = tick && (units_left_reg == 8'h01);

    // loading happens on entry to a timed state
    always_comb begin
        timer_load = 1'b0;
        if (state_reg == IOV_S_RUN && fault &&
            (cfg.react == iov_pkg::IOV_RIDE || cfg.react == iov_pkg::IOV_SHUT))
            timer_load = 1'b1;
        if (state_reg == IOV_S_WAIT && timer_done)
            timer_load = 1'b1;
        if (state_reg == IOV_S_RIDE && timer_done)
            timer_load = 1'b1;
    end

    // unit prescaler and unit counter, 2**delay units
    always_ff @(posedge clk) begin
        if (rst || timer_load) begin
            unit_cnt_reg   <= cfg.unit_cycles;
            units_left_reg <= 8'(9'h001 << cfg.delay_exp);
        end else if (tick) begin
            unit_cnt_reg <= cfg.unit_cycles;
            if (units_left_reg != 8'h01)
                units_left_reg <= units_left_reg - 8'h01;
        end else begin
            unit_cnt_reg <= unit_cnt_reg - 16'h0001;
        end
    end

    // main reaction sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= IOV_S_OFF;
            attempts_reg <= 3'h0;
        end else if (!on_cmd || other_shutdown) begin
            state_reg    <= IOV_S_OFF;
            attempts_reg <= 3'h0;
        end else begin
            case (state_reg)
                IOV_S_OFF: begin
                    state_reg <= IOV_S_RUN;
                end
                IOV_S_RUN: begin
                    if (fault) begin
                        case (cfg.react)
                            iov_pkg::IOV_IGNORE:    state_reg <= IOV_S_RUN;
                            iov_pkg::IOV_RIDE:      state_reg <= IOV_S_RIDE;
                            iov_pkg::IOV_SHUT:      state_reg <= (cfg.retries == iov_pkg::RETRY_NONE)
                                                    ? IOV_S_LATCH : IOV_S_WAIT;
                            default:                state_reg <= IOV_S_HOLD;
                        endcase
                    end
                end
                IOV_S_RIDE: begin
                    if (!fault)
                        state_reg <= IOV_S_RUN;
                    else if (timer_done)
                        state_reg <= (cfg.retries == iov_pkg::RETRY_NONE)
                                     ? IOV_S_LATCH : IOV_S_WAIT;
                end
                IOV_S_WAIT: begin
                    // restart attempt at the end of each spacing interval
                    if (timer_done) begin
                        if (!fault) begin
                            state_reg <= IOV_S_RUN;
                        end else if (cfg.retries == iov_pkg::RETRY_FOREVER) begin
                            state_reg <= IOV_S_WAIT;
                        end else if ((attempts_reg + 3'h1) >= cfg.retries) begin
                            // last attempt failed: latch now, not one interval later
                            state_reg <= IOV_S_LATCH;
                        end else begin
                            attempts_reg <= attempts_reg + 3'h1;
                        end
                    end
                end
                IOV_S_HOLD: begin
                    if (!fault)
                        state_reg <= IOV_S_RUN;
                end
                IOV_S_LATCH: begin
                    if (fault_clear) begin
                        state_reg    <= IOV_S_RUN;
                        attempts_reg <= 3'h0;
                    end
                end
                default: state_reg <= IOV_S_OFF;
            endcase
        end
    end

    // output reflects state; ride-through keeps running
    always_ff @(posedge clk) begin
        if (rst) begin
            out_enable  <= 1'b0;
            latched_off <= 1'b0;
            in_delay    <= 1'b0;
        end else begin
            out_enable  <= (state_reg == IOV_S_RUN) || (state_reg == IOV_S_RIDE);
            latched_off <= (state_reg == IOV_S_LATCH);
            in_delay    <= (state_reg == IOV_S_RIDE) || (state_reg == IOV_S_WAIT);
        end
    end
endmodule : iov_fault_engine

// >>> rtl/iov_supervisor.sv
`timescale 1ns/1ps
// input overvoltage supervision with command-coded register port
module iov_supervisor (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port, command code addressed
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_write,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_known,
    // measurement and control
    input  wire logic [15:0] vin_measured,
    input  wire logic        vin_valid,
    input  wire logic [15:0] unit_cycles,
    input  wire logic        on_cmd,
    input  wire logic        fault_clear,
    input  wire logic        other_shutdown,
    // status
    output logic             out_enable,
    output logic             ov_fault,
    output logic             ov_warning,
    output logic             latched_off,
    output logic             in_delay
);
    logic [15:0] trip_reg;
    logic [15:0] alert_reg;
    logic [7:0]  react_reg;

    iov_cfg_if cfg ();

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            trip_reg  <= iov_pkg::TRIP_RESET;
            alert_reg <= iov_pkg::ALERT_RESET;
            react_reg <= iov_pkg::REACTION_RESET;
        end else if (cmd_write) begin
            case (cmd_code)
                iov_pkg::CMD_TRIP_THRESHOLD:  trip_reg  <= cmd_wdata;
                iov_pkg::CMD_ALERT_THRESHOLD: alert_reg <= cmd_wdata;
                iov_pkg::CMD_REACTION_CONFIG: react_reg <= cmd_wdata[7:0];
                default: ;
            endcase
        end
    end

    // registered read data; unknown codes read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_rdata <= 16'h0000;
            cmd_known <= 1'b0;
        end else begin
            cmd_known <= 1'b1;
            case (cmd_code)
                iov_pkg::CMD_TRIP_THRESHOLD:  cmd_rdata <= trip_reg;
                iov_pkg::CMD_ALERT_THRESHOLD: cmd_rdata <= alert_reg;
                iov_pkg::CMD_REACTION_CONFIG: cmd_rdata <= {8'h00, react_reg};
                default: begin
                    cmd_rdata <= 16'h0000;
                    cmd_known <= 1'b0;
                end
            endcase
        end
    end

    // threshold compare on raw codes; both share one exponent in practice
    always_ff @(posedge clk) begin
        if (rst) begin
            ov_fault   <= 1'b0;
            ov_warning <= 1'b0;
        end else if (vin_valid) begin
            ov_fault   <= vin_measured > trip_reg;
            ov_warning <= vin_measured > alert_reg;
        end
    end

    assign cfg.react       = react_reg[iov_pkg::REACT_HI:iov_pkg::REACT_LO];
    assign cfg.retries     = react_reg[iov_pkg::RETRY_HI:iov_pkg::RETRY_LO];
    assign cfg.delay_exp   = react_reg[iov_pkg::DELAY_HI:iov_pkg::DELAY_LO];
    assign cfg.unit_cycles = unit_cycles;

    iov_fault_engine u_engine (
        .clk            (clk),
        .rst            (rst),
        .cfg            (cfg),
        .fault          (ov_fault),
        .fault_clear    (fault_clear),
        .on_cmd         (on_cmd),
        .other_shutdown (other_shutdown),
        .out_enable     (out_enable),
        .latched_off    (latched_off),
        .in_delay       (in_delay)
    );
endmodule : iov_supervisor

// >>> test/iov_host.sv
`timescale 1ns/1ps
// command port host, drives just after the falling edge
module iov_host (
    // clock
    input wire logic    clk,
    // command port
    output logic [7:0]  cmd_code,
    output logic        cmd_write,
    output logic [15:0] cmd_wdata
);
    // idle on an unmapped code so nothing is selected
    initial begin
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_wdata = 16'h0000;
    end
    // one write strobe; data is not left at the written value
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmd_code = c;
        cmd_write = 1'b1;
        cmd_wdata = d;
        @(negedge clk);
        cmd_write = 1'b0;
        cmd_wdata = ~d;
    endtask : wr
    // select a code; read data is settled one cycle later
    task automatic sel(input logic [7:0] c);
        @(negedge clk);
        cmd_code = c;
        @(negedge clk);
    endtask : sel
endmodule : iov_host

// >>> test/iov_checker.sv
`timescale 1ns/1ps
// port checks of the overvoltage supervisor
module iov_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register port
    input wire logic [7:0]  cmd_code,
    input wire logic        cmd_write,
    input wire logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic        cmd_known,
    // control and status
    input wire logic        vin_valid,
    input wire logic        on_cmd,
    input wire logic        other_shutdown,
    input wire logic        out_enable,
    input wire logic        ov_fault,
    input wire logic        latched_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] react_q;
    logic       mapped;
    // shadow of the reaction code, so checks know the mode
    always_ff @(posedge clk) begin
        if (rst)
            react_q <= 2'h2;
        else if (cmd_write && cmd_code == iov_pkg::CMD_REACTION_CONFIG)
            react_q <= cmd_wdata[7:6];
    end
    assign mapped = cmd_code inside {8'h55, 8'h56, 8'h57};
    sequence s_trip;
        $rose(ov_fault) && out_enable && react_q == 2'h2;
    endsequence
    sequence s_gone;
        (react_q == 2'h3 && on_cmd && !other_shutdown && !ov_fault && !latched_off)[*4];
    endsequence
    sequence s_run;
        (on_cmd && !other_shutdown)[*2] ##0 (out_enable && react_q == 2'h0);
    endsequence
    AST_SHUT: assert property (s_trip |-> ##2 !out_enable) else $error("still on");
    AST_RESUME: assert property (s_gone |-> out_enable) else $error("not back");
    AST_IGNORE: assert property (s_run |=> out_enable) else $error("stopped");
    AST_HOLD: assert property (!vin_valid |=> $stable(ov_fault)) else $error("moved");
    AST_OFF: assert property ((!on_cmd)[*3] |-> !out_enable) else $error("on");
    AST_LATCH: assert property (latched_off[*2] |-> !out_enable) else $error("on");
    AST_ON: assert property ($rose(out_enable) |-> $past(on_cmd, 2)) else $error("on");
    AST_KNOWN: assert property (mapped |=> cmd_known) else $error("not known");
    AST_UNMAP: assert property (!mapped |=> !cmd_known && cmd_rdata == 16'h0000)
        else $error("unmapped answered");
endmodule : iov_checker
bind iov_supervisor iov_checker chk_u (.clk, .rst, .cmd_code, .cmd_write, .cmd_wdata,
    .cmd_rdata, .cmd_known, .vin_valid, .on_cmd, .other_shutdown, .out_enable,
    .ov_fault, .latched_off);

// >>> test/tb_top.sv
`timescale 1ns/1ps
// self-checking bench, random fields from a fixed seed
module tb_top;
    logic        clk, rst, cmd_write, cmd_known, vin_valid, on_cmd, fault_clear;
    logic        other_shutdown, out_enable, ov_fault, ov_warning, latched_off, in_delay;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, vin_measured, unit_cycles, t, a;
    logic [15:0] shd [4] = '{16'hFFFF, 16'h0080, 16'hFFFF, 16'h0000};
    logic [31:0] seed;
    int          fails, checks, cyc, n;
    iov_host host_u (.clk, .cmd_code, .cmd_write, .cmd_wdata);
    iov_supervisor dut_u (.clk, .rst, .cmd_code, .cmd_write, .cmd_wdata, .cmd_rdata,
        .cmd_known, .vin_measured, .vin_valid, .unit_cycles, .on_cmd, .fault_clear,
        .other_shutdown, .out_enable, .ov_fault, .ov_warning, .latched_off, .in_delay);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // wait interval in clocks: 2^field units of unit_cycles+1
    function automatic int ivl(input logic [2:0] e);
        return (1 << e) * (int'(unit_cycles) + 1);
    endfunction : ivl
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // one sample strobe; vin moves off the value afterwards
    task automatic smp(input logic [15:0] v);
        @(negedge clk);
        vin_measured = v;
        vin_valid = 1'b1;
        @(negedge clk);
        vin_valid = 1'b0;
        vin_measured = ~v;
    endtask : smp
    // off long enough to reset attempts, run clean, then fault
    task automatic arm(input logic [7:0] r);
        on_cmd = 1'b0;
        host_u.wr(iov_pkg::CMD_REACTION_CONFIG, {8'h00, r});
        smp(a - 16'h0010);
        {on_cmd, fault_clear} = 2'h3;
        repeat (5) @(negedge clk);
        fault_clear = 1'b0;
        chk(out_enable, 1'b1);
        smp(t + 16'h0010);
    endtask : arm
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, well above the longest retry run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        {rst, vin_valid, on_cmd, fault_clear, other_shutdown} = 5'h10;
        {vin_measured, unit_cycles} = 32'h0;
        seed = 32'h21F4;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // read back each code, reset values first, then random writes
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            host_u.sel(8'h55 + 8'(i % 4));
            chk(cmd_rdata, shd[i % 4]);
            host_u.wr(8'h55 + 8'(i % 4), seed[15:0]);
            if (i % 4 != 3)
                shd[i % 4] = (i % 4 == 1) ? {8'h00, seed[7:0]} : seed[15:0];
        end
        t = 16'h4000 + {4'h0, seed[27:16]};
        a = t - 16'h0800;
        host_u.wr(iov_pkg::CMD_TRIP_THRESHOLD, t);
        host_u.wr(iov_pkg::CMD_ALERT_THRESHOLD, a);
        // above trip, at trip, above alert, at alert
        for (int i = 0; i < 4; i++) begin
            smp(i < 2 ? t + 16'(1 - i) : a + 16'(3 - i));
            chk(ov_fault, i == 0);
            chk(ov_warning, i < 3);
        end
        unit_cycles = 16'h0017 + 16'(seed[1:0]);
        arm({2'b00, seed[7:2]});
        repeat (400) @(negedge clk);
        chk(out_enable, 1'b1);
        arm({2'b11, seed[7:2]});
        // fault flag, then state, then output: two more edges before the output drops
        repeat (2) @(negedge clk);
        chk(out_enable, 1'b0);
        smp(a - 16'h0010);
        repeat (3) @(negedge clk);
        chk(out_enable, 1'b1);
        // persistent fault: retries spaced by the delay, then latched
        for (int r = 0; r < 7; r++) begin
            seed = xs(seed);
            arm({2'b10, 3'(r), 1'b0, seed[3:2]});
            for (n = 0; latched_off !== 1'b1 && n < 5000; n++) @(negedge clk);
            chk(n >= r * ivl({1'b0, seed[3:2]}) - 1, 1'b1);
            chk(n <= r * (ivl({1'b0, seed[3:2]}) + 2) + 4, 1'b1);
            smp(a - 16'h0010);
            repeat (50) @(negedge clk);
            chk(out_enable | !latched_off, 1'b0);
        end
        arm(8'h98);
        smp(a - 16'h0010);
        repeat (ivl(3'h0) + 10) @(negedge clk);
        chk(out_enable & !latched_off, 1'b1);
        arm(8'hB8);
        repeat (2000) @(negedge clk);
        chk(latched_off, 1'b0);
        smp(a - 16'h0010);
        repeat (ivl(3'h0) + 10) @(negedge clk);
        chk(out_enable, 1'b1);
        other_shutdown = 1'b1;
        repeat (4) @(negedge clk);
        chk(out_enable, 1'b0);
        other_shutdown = 1'b0;
        unit_cycles = 16'h0000;
        arm(8'h47);
        repeat (120) @(negedge clk);
        chk(out_enable & in_delay, 1'b1);
        repeat (20) @(negedge clk);
        chk(out_enable | !latched_off, 1'b0);
        // ride-through cut short by the fault going away
        arm(8'h47);
        repeat (60) @(negedge clk);
        smp(a - 16'h0010);
        repeat (200) @(negedge clk);
        chk(out_enable & !latched_off & !in_delay, 1'b1);
        // ride-through of four units, one failed retry, then latched
        arm(8'h4A);
        repeat (20) @(negedge clk);
        chk(latched_off & !out_enable, 1'b1);
        conclude();
    end
endmodule : tb_top
